// ### logic/pomwc_mode_ctrl.sv
// Operating-mode and wake-up controller of the single-pair PHY
`timescale 1ns/100ps
`default_nettype none
`include "pomwc_regs.svh"
module pomwc_mode_ctrl
	import pomwc_pkg::*;
#(
	parameter int unsigned WAKE_REQ_CYCLES =
		`POMWC_WAKE_REQ_MIN_MS * `POMWC_CLK_KHZ,
	parameter int unsigned SLEEP_REQ_CYCLES =
		`POMWC_SLEEP_REQ_TIMEOUT_MS * `POMWC_CLK_KHZ,
	parameter int unsigned IDLE_PD_CYCLES =
		`POMWC_IDLE_PD_TIMEOUT_MS * `POMWC_CLK_KHZ
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Device pins
	input wire logic rst_pin_b_i,
	input wire logic en_pin_i,
	output logic en_pin_o,
	output logic en_pin_oe_o,
	input wire logic wake_pin_i,
	output logic supply_hold_output_o,
	// Supply and temperature monitors
	input wire logic vio_uv_i,
	input wire logic vddd_uv_i,
	input wire logic vdda_uv_i,
	input wire logic overtemp_i,
	// Management commands, one-cycle pulses
	input wire logic cmd_normal_i,
	input wire logic cmd_standby_i,
	input wire logic cmd_sleep_i,
	// Configuration bits
	input wire logic indicator_pin_select_i,
	input wire logic self_run_config_i,
	input wire logic idle_power_down_enable_i,
	input wire logic hold_in_disable_i,
	input wire logic link_permit_i,
	input wire logic wake_request_i,
	input wire logic test_mode_i,
	input wire logic slave_jitter_test_i,
	// Line and MAC activity
	input wire logic mdi_idle_pulse_i,
	input wire logic mdi_frame_i,
	input wire logic mii_frame_i,
	input wire logic mii_tx_en_i,
	// Mode and block enables
	output pomwc_mode_type mode_o,
	output logic tx_en_o,
	output logic rx_en_o,
	output logic mgmt_en_o,
	output logic act_det_en_o,
	output logic osc_en_o,
	output logic ldo_en_o,
	output logic mii_out_oe_o,
	output logic mii_rx_low_o,
	output logic mii_pulldown_o,
	output logic wake_in_en_o,
	output logic led_en_o,
	output logic tx_req_o,
	output logic regs_default_o,
	// Wake request and link start
	output logic send_idle_o,
	output logic wake_req_min_met_o,
	output logic link_start_o,
	// Wake flags and event
	output logic local_wake_flag_o,
	output logic remote_wake_flag_o,
	output logic frame_seen_wake_flag_o,
	output logic rouse_event_irq_o
);
	localparam int unsigned RST_DET_CYCLES =
		(`POMWC_RST_DET_US * `POMWC_CLK_KHZ + 999) / 1000;

	pomwc_mode_type state;
	pomwc_mode_type next_state;
	pomwc_blk_type blk;
	logic test_act;
	logic en_int;
	logic io_uv;
	logic ana_bad;
	logic rst_det;
	logic frame_any;
	logic wake_q;
	logic ev_local;
	logic ev_remote;
	logic ev_frame;
	logic flag_clr;
	logic [3:0] div_cnt;

	pomwc_tmr_if tmr [`POMWC_TMR_N] ();

	//------------------------------------------------------------------
	// Block enables per mode
	//------------------------------------------------------------------
	// Decode of enables for a mode
	function automatic pomwc_blk_type blk_of(input pomwc_mode_type m,
		input logic sel, input logic hold_dis);
		pomwc_blk_type b;
		b = '0;
		case (m)
			MODE_NORMAL: begin
				b.tx = 1'b1;
				b.rx = 1'b1;
				b.mgmt = 1'b1;
				b.osc = 1'b1;
				b.ldo = 1'b1;
				b.mii_oe = 1'b1;
				b.led = sel;
				b.hold = 1'b1;
			end
			MODE_SLEEP_REQ: begin
				b.tx = 1'b1;
				b.rx = 1'b1;
				b.mgmt = 1'b1;
				b.osc = 1'b1;
				b.ldo = 1'b1;
				b.mii_oe = 1'b1;
				b.led = sel;
				b.wake_in = !sel;
				b.hold = 1'b1;
			end
			MODE_SLEEP: begin
				b.act_det = 1'b1;
				b.wake_in = !sel;
				b.hold = 1'b0;
			end
			MODE_DISABLE: begin
				b.hold = hold_dis;
			end
			MODE_RESET: begin
				b.mgmt = 1'b1;
				b.ldo = 1'b1;
				b.hold = 1'b1;
			end
			default: begin
				// Standby: fail-silent, receive outputs low
				b.mgmt = 1'b1;
				b.act_det = 1'b1;
				b.ldo = 1'b1;
				b.mii_rx_low = 1'b1;
				b.mii_pd = 1'b1;
				b.wake_in = !sel;
				b.hold = 1'b1;
			end
		endcase
		return b;
	endfunction : blk_of

	//------------------------------------------------------------------
	// Timers
	//------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `POMWC_TMR_N; g++) begin : g_tmr
			pomwc_timer u_tmr (
				.ref_clk_i(ref_clk_i),
				.rst_b_i(rst_b_i),
				.tmr(tmr[g])
			);
		end
	endgenerate

	// Restart conditions and limits of each timer
	assign tmr[`POMWC_TMR_WAKE].restart = !send_idle_o;
	assign tmr[`POMWC_TMR_WAKE].limit = `POMWC_TMR_W'(WAKE_REQ_CYCLES);
	assign tmr[`POMWC_TMR_SLEEP].restart = state != MODE_SLEEP_REQ;
	assign tmr[`POMWC_TMR_SLEEP].limit = `POMWC_TMR_W'(SLEEP_REQ_CYCLES);
	assign tmr[`POMWC_TMR_IDLE].restart = state != MODE_NORMAL || frame_any;
	assign tmr[`POMWC_TMR_IDLE].limit = `POMWC_TMR_W'(IDLE_PD_CYCLES);
	assign tmr[`POMWC_TMR_RST].restart = rst_pin_b_i;
	assign tmr[`POMWC_TMR_RST].limit = `POMWC_TMR_W'(RST_DET_CYCLES);

	//------------------------------------------------------------------
	// Trigger conditions
	//------------------------------------------------------------------
	// Enable forced high while the pin serves as test clock
	assign en_int = test_act ? 1'b1 : en_pin_i;
	// Supplies are lost in Sleep once hold is released, so ignore there
	assign io_uv = (vio_uv_i || vddd_uv_i) && state != MODE_SLEEP;
	assign ana_bad = overtemp_i || vdda_uv_i;
	assign rst_det = tmr[`POMWC_TMR_RST].done && !rst_pin_b_i;
	assign frame_any = mdi_frame_i || mii_frame_i;

	// Wake sources
	assign ev_local = wake_q && !wake_pin_i && !indicator_pin_select_i &&
		(state == MODE_STANDBY || state == MODE_SLEEP_REQ ||
		state == MODE_SLEEP);
	assign ev_remote = (mdi_idle_pulse_i || mdi_frame_i) &&
		(state == MODE_STANDBY || state == MODE_SLEEP);
	assign ev_frame = frame_any && state == MODE_SLEEP_REQ;
	assign flag_clr = next_state != state &&
		(next_state == MODE_SLEEP_REQ || next_state == MODE_SLEEP);

	//------------------------------------------------------------------
	// Mode machine
	//------------------------------------------------------------------
	// Next mode, highest priority trigger first
	always_comb begin
		next_state = state;
		if (io_uv) begin
			next_state = MODE_STANDBY;
		end else if (rst_det) begin
			next_state = MODE_RESET;
		end else if (state == MODE_RESET) begin
			next_state = MODE_STANDBY;
		end else if (!en_int && state != MODE_SLEEP) begin
			next_state = MODE_DISABLE;
		end else if (state == MODE_DISABLE) begin
			next_state = MODE_STANDBY;
		end else if (ana_bad && (state == MODE_NORMAL ||
			state == MODE_SLEEP_REQ)) begin
			next_state = MODE_STANDBY;
		end else begin
			case (state)
				MODE_STANDBY: begin
					if (cmd_sleep_i) begin
						next_state = MODE_SLEEP;
					end else if ((self_run_config_i || cmd_normal_i) &&
						!ana_bad) begin
						next_state = MODE_NORMAL;
					end
				end
				MODE_NORMAL: begin
					if (cmd_standby_i) begin
						next_state = MODE_STANDBY;
					end else if (cmd_sleep_i || (idle_power_down_enable_i &&
						tmr[`POMWC_TMR_IDLE].done)) begin
						next_state = MODE_SLEEP_REQ;
					end
				end
				MODE_SLEEP_REQ: begin
					if (frame_any || cmd_normal_i) begin
						next_state = MODE_NORMAL;
					end else if (tmr[`POMWC_TMR_SLEEP].done) begin
						next_state = MODE_SLEEP;
					end
				end
				MODE_SLEEP: begin
					if (ev_remote || ev_local) begin
						next_state = MODE_STANDBY;
					end
				end
				default: begin
					next_state = MODE_STANDBY;
				end
			endcase
		end
	end

	// Mode register, one encoded machine
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= MODE_STANDBY;
		end else begin
			state <= next_state;
		end
	end

	// Registered block enables of the coming mode
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			blk <= '0;
			blk.hold <= 1'b1;
			regs_default_o <= 1'b0;
			tx_req_o <= 1'b0;
		end else begin
			blk <= blk_of(next_state, indicator_pin_select_i,
				hold_in_disable_i);
			regs_default_o <= next_state == MODE_RESET;
			tx_req_o <= mii_tx_en_i && next_state == MODE_NORMAL;
		end
	end

	assign mode_o = state;
	assign tx_en_o = blk.tx;
	assign rx_en_o = blk.rx;
	assign mgmt_en_o = blk.mgmt;
	assign act_det_en_o = blk.act_det;
	assign osc_en_o = blk.osc;
	assign ldo_en_o = blk.ldo;
	assign mii_out_oe_o = blk.mii_oe;
	assign mii_rx_low_o = blk.mii_rx_low;
	assign mii_pulldown_o = blk.mii_pd;
	assign wake_in_en_o = blk.wake_in;
	assign led_en_o = blk.led;
	assign supply_hold_output_o = blk.hold;

	//------------------------------------------------------------------
	// Test clock on the enable pin
	//------------------------------------------------------------------
	// Divider toggles the pin every half period while testing
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			test_act <= 1'b0;
			div_cnt <= '0;
			en_pin_o <= 1'b0;
		end else begin
			test_act <= state == MODE_NORMAL && (test_mode_i ||
				(slave_jitter_test_i && link_permit_i));
			if (!test_act || div_cnt == 4'(`POMWC_TEST_CLK_HALF - 1)) begin
				div_cnt <= '0;
			end else begin
				div_cnt <= div_cnt + 4'h1;
			end
			if (!test_act) begin
				en_pin_o <= 1'b0;
			end else if (div_cnt == 4'(`POMWC_TEST_CLK_HALF - 1)) begin
				en_pin_o <= !en_pin_o;
			end
		end
	end
	assign en_pin_oe_o = test_act;

	//------------------------------------------------------------------
	// Wake request and autonomous link start
	//------------------------------------------------------------------
	// Idle symbols while requested; abort as soon as bit or permit change
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			send_idle_o <= 1'b0;
			link_start_o <= 1'b0;
		end else begin
			send_idle_o <= next_state == MODE_NORMAL && wake_request_i &&
				!link_permit_i;
			link_start_o <= next_state == MODE_NORMAL && self_run_config_i;
		end
	end
	assign wake_req_min_met_o = tmr[`POMWC_TMR_WAKE].done;

	//------------------------------------------------------------------
	// Wake flags and event
	//------------------------------------------------------------------
	// Edge detect of the wake pin
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wake_q <= 1'b1;
		end else begin
			wake_q <= wake_pin_i;
		end
	end

	// Sticky source flags, a new event wins over the entry clear
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			local_wake_flag_o <= `POMWC_FLAG_RST;
			remote_wake_flag_o <= `POMWC_FLAG_RST;
			frame_seen_wake_flag_o <= `POMWC_FLAG_RST;
			rouse_event_irq_o <= 1'b0;
		end else begin
			if (ev_local) begin
				local_wake_flag_o <= 1'b1;
			end else if (flag_clr) begin
				local_wake_flag_o <= 1'b0;
			end
			if (ev_remote) begin
				remote_wake_flag_o <= 1'b1;
			end else if (flag_clr) begin
				remote_wake_flag_o <= 1'b0;
			end
			if (ev_frame) begin
				frame_seen_wake_flag_o <= 1'b1;
			end else if (flag_clr) begin
				frame_seen_wake_flag_o <= 1'b0;
			end
			rouse_event_irq_o <= ev_local || ev_remote || ev_frame;
		end
	end

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	disable_entry_a: assert property (
		!en_pin_i && !test_act && !io_uv && !rst_det &&
		state != MODE_RESET && state != MODE_SLEEP
		|=> state == MODE_DISABLE &&
		supply_hold_output_o == $past(hold_in_disable_i)
	) else $error("enable low did not disable");

	sleep_quiet_a: assert property (
		state == MODE_SLEEP && $past(state) == MODE_SLEEP |->
		!tx_en_o && !rx_en_o && !mgmt_en_o && !mii_out_oe_o && !tx_req_o
	) else $error("sleep mode not quiet");

	sleep_hold_a: assert property (
		next_state == MODE_SLEEP |=> !supply_hold_output_o
	) else $error("hold not released in sleep");

	sleep_origin_a: assert property (
		state == MODE_SLEEP && $past(state) != MODE_SLEEP |->
		$past(state) == MODE_STANDBY || $past(state) == MODE_SLEEP_REQ
	) else $error("sleep entered from wrong mode");

	frame_return_a: assert property (
		ev_frame && !io_uv && !rst_det && en_int && !ana_bad |=>
		state == MODE_NORMAL && frame_seen_wake_flag_o && rouse_event_irq_o
	) else $error("frame in sleep request not handled");

	standby_rx_a: assert property (
		$past(rst_b_i) && state == MODE_STANDBY &&
		$past(state) == MODE_STANDBY |->
		mii_rx_low_o && mii_pulldown_o && !mii_out_oe_o && !rx_en_o
	) else $error("standby receive outputs not held");

	reset_entry_a: assert property (
		!rst_pin_b_i [*8] ##1 rst_det && !io_uv |=> state == MODE_RESET
		&& regs_default_o
	) else $error("reset pin did not reset");

	uv_standby_a: assert property (
		io_uv |=> state == MODE_STANDBY
	) else $error("undervoltage did not fall back");

	wake_abort_a: assert property (
		!wake_request_i || link_permit_i |=> !send_idle_o
	) else $error("wake request not aborted");

	flag_clear_a: assert property (
		flag_clr && !ev_local && !ev_remote && !ev_frame |=>
		!local_wake_flag_o && !remote_wake_flag_o && !frame_seen_wake_flag_o
	) else $error("wake flags not cleared");

	local_wake_a: assert property (
		ev_local |=> local_wake_flag_o && rouse_event_irq_o
	) else $error("local wake lost");

	sel_exclusive_a: assert property (
		!(wake_in_en_o && led_en_o)
	) else $error("wake input and LED both active");

	sleep_wake_c: cover property (
		state == MODE_SLEEP ##1 state == MODE_STANDBY ##[1:20]
		state == MODE_NORMAL
	);
	sleep_path_c: cover property (
		state == MODE_NORMAL ##1 state == MODE_SLEEP_REQ ##[1:200]
		state == MODE_SLEEP
	);
	reset_path_c: cover property (
		state == MODE_RESET ##[1:50] state == MODE_STANDBY
	);
	disable_path_c: cover property (
		state == MODE_DISABLE ##[1:50] state == MODE_STANDBY
	);
endmodule : pomwc_mode_ctrl
`default_nettype wire

// ### logic/pomwc_pkg.sv
// Types of the PHY mode and wake-up controller
`default_nettype none
`include "pomwc_regs.svh"
package pomwc_pkg;

	typedef enum logic [2:0] {
		MODE_STANDBY,
		MODE_NORMAL,
		MODE_SLEEP_REQ,
		MODE_SLEEP,
		MODE_DISABLE,
		MODE_RESET
	} pomwc_mode_type;

	typedef struct packed {
		logic tx;
		logic rx;
		logic mgmt;
		logic act_det;
		logic osc;
		logic ldo;
		logic mii_oe;
		logic mii_rx_low;
		logic mii_pd;
		logic wake_in;
		logic led;
		logic hold;
	} pomwc_blk_type;

endpackage : pomwc_pkg
`default_nettype wire

// ### logic/pomwc_regs.svh
// Constants and timing figures of the PHY mode and wake-up controller
//----------------------------------------------------------------------
// How it works
// - Enable pin low outside Sleep enters Disable keeping configuration; high again reactivates.
// - Configuration is kept through Sleep; register defaults only in Reset.
// - Sleep disables TX, RX, MAC outputs, MAC transmit requests and management.
// - Entering Sleep releases the supply-hold output.
// - Idle pulses in Sleep wake the device and reassert supply hold.
// - Sleep is entered only from Standby or through Sleep Request.
// - Sleep Request runs a timer; on expiry go to Sleep, hold off.
// - Frame during Sleep Request returns to Normal, sets frame flag, interrupt.
// - Standby holds receive outputs low, other MAC pins pulled down.
// - Select 0 enables wake input; select 1 enables the LED output.
// - Test modes use the enable pin as clock out, enable forced high.
// - Supply-hold level in Disable comes from a configuration input.
// - Reset pin low for the detection time enters Reset from anywhere.
// - Reset mode restores defaults; pin high or I/O undervoltage goes Standby.
// - Transition triggers follow a fixed priority, supplies first, commands last.
// - Wake request in Normal with link permit clear sends idle symbols.
// - Wake request stops when its bit clears or link permit sets.
// - Wake events set source flags and interrupt; flags clear entering sleep.
// - Cable activity in Standby or Sleep is a remote wake-up.
// - Wake pin falling edge is a local wake-up when select is 0.
// - Self-run goes to Normal on power-on or wake and starts link.
// - Idle power-down enters Sleep Request after no frames for the timeout.
// - Normal is entered by self-run or by a host command.
// - I/O or digital supply undervoltage outside Sleep falls back to fail-silent Standby.
//----------------------------------------------------------------------
`ifndef POMWC_REGS_SVH
`define POMWC_REGS_SVH

// Clock rate in kHz
`define POMWC_CLK_KHZ 125000
// Times in their own units
`define POMWC_WAKE_REQ_MIN_MS 5
`define POMWC_SLEEP_REQ_TIMEOUT_MS 4
`define POMWC_IDLE_PD_TIMEOUT_MS 8
`define POMWC_RST_DET_US 20
// Half period of the test clock in cycles
`define POMWC_TEST_CLK_HALF 5
// Timer width and timer slots
`define POMWC_TMR_W 20
`define POMWC_TMR_N 4
`define POMWC_TMR_WAKE 0
`define POMWC_TMR_SLEEP 1
`define POMWC_TMR_IDLE 2
`define POMWC_TMR_RST 3
// Reset value of wake flags
`define POMWC_FLAG_RST 1'b0

`endif

// ### logic/pomwc_timer.sv
// Restartable timeout counter with sticky done
`timescale 1ns/100ps
`default_nettype none
`include "pomwc_regs.svh"
module pomwc_timer (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Timer control
	pomwc_tmr_if.cnt tmr
);
	logic [`POMWC_TMR_W-1:0] count;

	// Count up to limit, then hold done until restart
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count <= '0;
			tmr.done <= 1'b0;
		end else if (tmr.restart) begin
			count <= '0;
			tmr.done <= 1'b0;
		end else if (!tmr.done) begin
			if (count >= tmr.limit - `POMWC_TMR_W'(1)) begin
				tmr.done <= 1'b1;
			end else begin
				count <= count + `POMWC_TMR_W'(1);
			end
		end
	end
endmodule : pomwc_timer
`default_nettype wire

// ### logic/pomwc_tmr_if.sv
// Control and status of one timeout counter
`timescale 1ns/100ps
`default_nettype none
`include "pomwc_regs.svh"
interface pomwc_tmr_if;
	logic restart;
	logic [`POMWC_TMR_W-1:0] limit;
	logic done;
	modport ctrl (output restart, output limit, input done);
	modport cnt (input restart, input limit, output done);
endinterface : pomwc_tmr_if
`default_nettype wire

// ### verification/pomwc_partner.sv
// Link partner model that makes activity on the cable
`timescale 1ns/100ps
`default_nettype none
module pomwc_partner (
	// Clock
	input wire logic ref_clk_i,
	// Cable activity
	output logic idle_pulse_o,
	output logic frame_o
);
	// Quiet cable until asked
	initial begin
		idle_pulse_o = 1'b0;
		frame_o = 1'b0;
	end
	// Idle pulses, also the training seen as wake request
	task automatic pulses(input int n);
		@(negedge ref_clk_i);
		idle_pulse_o = 1'b1;
		repeat (n) @(negedge ref_clk_i);
		idle_pulse_o = 1'b0;
	endtask : pulses
	// One frame on the cable
	task automatic frame(input int n);
		@(negedge ref_clk_i);
		frame_o = 1'b1;
		repeat (n) @(negedge ref_clk_i);
		frame_o = 1'b0;
	endtask : frame
endmodule : pomwc_partner
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench of the mode and wake-up controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pomwc_pkg::*;
	logic clk;
	logic rst_b = 0, rst_pin_b = 1, en_pin = 1, wake_pin = 1, vio_uv = 0;
	logic vddd_uv = 0, vdda_uv = 0, overtemp = 0, sjt = 0, c_stby = 0;
	logic c_norm = 0, c_slp = 0, sel = 0, self_run = 0, idle_pd = 0;
	logic hold_dis = 0, lperm = 0, wreq = 0, tmode = 0, mii_fr = 0;
	logic mii_tx = 0, ipulse, mframe;
	logic hold, tx_en, mgmt, mii_oe, rx_low, wake_en, led, tx_req, rdef;
	logic idle, met, lstart, lflag, rflag, fflag, irq, en_oe;
	logic rx_en, act_det, osc, ldo, pulld, en_out;
	pomwc_mode_type mode;
	int bad_count = 0;
	int samples_checked = 0;
	pomwc_partner lp (.ref_clk_i(clk), .idle_pulse_o(ipulse),
		.frame_o(mframe));
	pomwc_mode_ctrl #(.WAKE_REQ_CYCLES(20), .SLEEP_REQ_CYCLES(20),
		.IDLE_PD_CYCLES(30)) dut (
		.ref_clk_i(clk), .rst_b_i(rst_b), .rst_pin_b_i(rst_pin_b),
		.en_pin_i(en_pin), .en_pin_o(en_out), .en_pin_oe_o(en_oe),
		.wake_pin_i(wake_pin), .supply_hold_output_o(hold),
		.vio_uv_i(vio_uv), .vddd_uv_i(vddd_uv), .vdda_uv_i(vdda_uv),
		.overtemp_i(overtemp), .cmd_normal_i(c_norm),
		.cmd_standby_i(c_stby), .cmd_sleep_i(c_slp),
		.indicator_pin_select_i(sel), .self_run_config_i(self_run),
		.idle_power_down_enable_i(idle_pd), .hold_in_disable_i(hold_dis),
		.link_permit_i(lperm), .wake_request_i(wreq), .test_mode_i(tmode),
		.slave_jitter_test_i(sjt), .mdi_idle_pulse_i(ipulse),
		.mdi_frame_i(mframe), .mii_frame_i(mii_fr), .mii_tx_en_i(mii_tx),
		.mode_o(mode), .tx_en_o(tx_en), .rx_en_o(rx_en), .mgmt_en_o(mgmt),
		.act_det_en_o(act_det), .osc_en_o(osc), .ldo_en_o(ldo),
		.mii_out_oe_o(mii_oe), .mii_rx_low_o(rx_low),
		.mii_pulldown_o(pulld), .wake_in_en_o(wake_en),
		.led_en_o(led), .tx_req_o(tx_req), .regs_default_o(rdef),
		.send_idle_o(idle), .wake_req_min_met_o(met),
		.link_start_o(lstart), .local_wake_flag_o(lflag),
		.remote_wake_flag_o(rflag), .frame_seen_wake_flag_o(fflag),
		.rouse_event_irq_o(irq));
	// Clock of 8 ns
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Falling edges, where inputs change
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Compare and count
	task automatic chk(input string nm, input logic [3:0] s,
		input logic [3:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Verdict and end of run
	task automatic give_verdict();
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// Reset held 4 cycles
	task automatic rst();
		rst_b = 1'b0;
		cyc(4);
		rst_b = 1'b1;
		cyc(1);
	endtask : rst
	// One-cycle command: 0 normal, 1 sleep, 2 standby
	task automatic cmd(input int k);
		if (k == 0)
			c_norm = 1'b1;
		else if (k == 1)
			c_slp = 1'b1;
		else
			c_stby = 1'b1;
		cyc(1);
		c_norm = 1'b0;
		c_slp = 1'b0;
		c_stby = 1'b0;
	endtask : cmd
	// Sleep entry, timer, remote wake
	task automatic t_sleep();
		chk("rx_low", rx_low, 1);
		chk("pulldown", pulld, 1);
		chk("act_det", act_det, 1);
		chk("ldo", ldo, 1);
		chk("tx_en", tx_en, 0);
		cmd(0);
		chk("mode", mode, MODE_NORMAL);
		chk("tx_en", tx_en, 1);
		chk("rx_en", rx_en, 1);
		chk("osc", osc, 1);
		cmd(1);
		chk("mode", mode, MODE_SLEEP_REQ);
		cyc(20);
		chk("mode", mode, MODE_SLEEP_REQ);
		mii_tx = 1'b1;
		cyc(1);
		chk("mode", mode, MODE_SLEEP);
		chk("hold", hold, 0);
		chk("mgmt", mgmt, 0);
		chk("mii_oe", mii_oe, 0);
		chk("tx_req", tx_req, 0);
		chk("rx_en", rx_en, 0);
		chk("ldo", ldo, 0);
		chk("act_det", act_det, 1);
		lp.pulses(1);
		chk("mode", mode, MODE_STANDBY);
		chk("hold", hold, 1);
		chk("remote", rflag, 1);
		chk("irq", irq, 1);
		cyc(1);
		chk("irq", irq, 0);
	endtask : t_sleep
	// Frame during sleep request, flags cleared on entry
	task automatic t_frame();
		cmd(0);
		cmd(1);
		chk("remote", rflag, 0);
		mii_fr = 1'b1;
		cyc(1);
		mii_fr = 1'b0;
		chk("mode", mode, MODE_NORMAL);
		chk("frame", fflag, 1);
		chk("irq", irq, 1);
		cyc(1);
		chk("tx_req", tx_req, 1);
		mii_tx = 1'b0;
	endtask : t_frame
	// Wake pin and indicator select
	task automatic t_local();
		rst();
		chk("wake_en", wake_en, 1);
		wake_pin = 1'b0;
		repeat (4) if (irq !== 1'b1) cyc(1);
		chk("local", lflag, 1);
		wake_pin = 1'b1;
		sel = 1'b1;
		cmd(0);
		chk("wake_en", wake_en, 0);
		chk("led", led, 1);
		cmd(1);
		wake_pin = 1'b0;
		cyc(4);
		chk("local", lflag, 0);
		wake_pin = 1'b1;
		sel = 1'b0;
	endtask : t_local
	// Slave wake request and its aborts
	task automatic t_wreq();
		rst();
		cmd(0);
		wreq = 1'b1;
		cyc(1);
		chk("idle", idle, 1);
		cyc(19);
		chk("met", met, 0);
		cyc(1);
		chk("met", met, 1);
		lperm = 1'b1;
		cyc(1);
		chk("idle", idle, 0);
		lperm = 1'b0;
		cyc(1);
		wreq = 1'b0;
		cyc(1);
		chk("idle", idle, 0);
	endtask : t_wreq
	// Enable pin against command, supply hold in Disable, undervoltage
	task automatic t_dis();
		for (int h = 0; h < 2; h++) begin
			hold_dis = h[0];
			en_pin = 1'b0;
			cmd(0);
			chk("mode", mode, MODE_DISABLE);
			chk("hold", hold, h[3:0]);
			chk("tx_en", tx_en, 0);
			en_pin = 1'b1;
			cyc(1);
			chk("mode", mode, MODE_STANDBY);
		end
		cmd(0);
		vio_uv = 1'b1;
		en_pin = 1'b0;
		cyc(1);
		chk("mode", mode, MODE_STANDBY);
		chk("tx_en", tx_en, 0);
		vio_uv = 1'b0;
		en_pin = 1'b1;
		cyc(1);
	endtask : t_dis
	// Self-run start and idle power-down
	task automatic t_self();
		int n;
		rst();
		self_run = 1'b1;
		cyc(2);
		chk("mode", mode, MODE_NORMAL);
		chk("lstart", lstart, 1);
		idle_pd = 1'b1;
		n = 0;
		while (mode !== MODE_SLEEP_REQ && n < 40) begin
			cyc(1);
			n++;
		end
		chk("pd_time", (n > 27 && n < 33), 1);
		cyc(21);
		lp.pulses(1);
		cyc(1);
		chk("mode", mode, MODE_NORMAL);
		self_run = 1'b0;
		idle_pd = 1'b0;
	endtask : t_self
	// Reset pin detection and release
	task automatic t_rpin();
		rst();
		cmd(0);
		rst_pin_b = 1'b0;
		cyc(2490);
		chk("mode", mode, MODE_NORMAL);
		repeat (20) if (mode !== MODE_RESET) cyc(1);
		chk("mode", mode, MODE_RESET);
		chk("rdef", rdef, 1);
		rst_pin_b = 1'b1;
		cyc(2);
		chk("mode", mode, MODE_STANDBY);
	endtask : t_rpin
	// Test mode turns the enable pin around
	task automatic t_test();
		cmd(0);
		tmode = 1'b1;
		cyc(2);
		chk("en_oe", en_oe, 1);
		en_pin = 1'b0;
		cyc(2);
		chk("mode", mode, MODE_NORMAL);
		chk("en_out", en_out, 0);
		cyc(2);
		chk("en_out", en_out, 1);
		en_pin = 1'b1;
		tmode = 1'b0;
		cyc(2);
		chk("en_oe", en_oe, 0);
	endtask : t_test
	// Standby command, sleep from Standby, frame wake, supply faults
	task automatic t_misc();
		cmd(2);
		chk("mode", mode, MODE_STANDBY);
		cmd(1);
		chk("mode", mode, MODE_SLEEP);
		chk("hold", hold, 0);
		lp.frame(1);
		chk("mode", mode, MODE_STANDBY);
		chk("remote", rflag, 1);
		cmd(0);
		overtemp = 1'b1;
		cyc(1);
		chk("mode", mode, MODE_STANDBY);
		overtemp = 1'b0;
		cmd(0);
		sjt = 1'b1;
		lperm = 1'b1;
		cyc(2);
		chk("en_oe", en_oe, 1);
		sjt = 1'b0;
		vddd_uv = 1'b1;
		cyc(1);
		chk("mode", mode, MODE_STANDBY);
		vddd_uv = 1'b0;
		lperm = 1'b0;
		cyc(1);
		chk("en_oe", en_oe, 0);
	endtask : t_misc
	// Main sequence
	initial begin
		cyc(4);
		rst_b = 1'b1;
		cyc(1);
		t_sleep();
		t_frame();
		t_local();
		t_wreq();
		t_dis();
		t_self();
		t_rpin();
		t_test();
		t_misc();
		give_verdict();
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
